/* sebw_pkg.sv */
package sebw_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned DEPTH         = 256;
   localparam logic [15:0] ERASED_WORD   = 16'hFFFF;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned PROG_TIME_NS  = 5_000_000;
   localparam int unsigned PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned PIN_N         = 4;
   localparam int unsigned PIN_CS        = 0;
   localparam int unsigned PIN_SCLK      = 1;
   localparam int unsigned PIN_SIN       = 2;
   localparam int unsigned PIN_WSEL      = 3;
   localparam logic [3:0]  PIN_RST       = 4'h8;
   localparam int unsigned SH_W          = 26;
   localparam logic [4:0]  HDR_LEN_X16   = 5'h0A;
   localparam logic [4:0]  HDR_LEN_X8    = 5'h0B;
   localparam logic [4:0]  DATA_LEN_X16  = 5'h10;
   localparam logic [4:0]  DATA_LEN_X8   = 5'h08;
   localparam logic [4:0]  FIELD_LEN     = 5'h04;
   localparam logic [1:0]  OP_BULK       = 2'h0;
   localparam logic [1:0]  SUB_DISABLE   = 2'h0;
   localparam logic [1:0]  SUB_WRITE_ALL = 2'h1;
   localparam logic [1:0]  SUB_ERASE_ALL = 2'h2;
   localparam logic [1:0]  SUB_ENABLE    = 2'h3;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HDR  = 4'h2,
      ST_DATA = 4'h4,
      ST_DONE = 4'h8
   } sebw_state_e;
endpackage

/* sebw_cyc_if.sv */
`timescale 1ns/100ps
interface sebw_cyc_if;
   logic                        start;
   logic                        erase;
   logic [sebw_pkg::DATA_W-1:0] data;
   logic                        busy;
   logic [sebw_pkg::ADDR_W-1:0] rd_addr;
   logic [sebw_pkg::DATA_W-1:0] rd_data;
   modport ctl (output start, erase, data, rd_addr, input busy, rd_data);
   modport eng (input start, erase, data, rd_addr, output busy, rd_data);
endinterface

/* sebw_bulk_engine.sv */
`timescale 1ns/100ps
module sebw_bulk_engine #(
   parameter int unsigned PROG_CYCLES = sebw_pkg::PROG_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   sebw_cyc_if.eng   cyc
);
   localparam int unsigned CW = $clog2(PROG_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(PROG_CYCLES - 1);

   logic [sebw_pkg::DATA_W-1:0] mem_reg [sebw_pkg::DEPTH];
   logic [sebw_pkg::DATA_W-1:0] data_reg;
   logic [sebw_pkg::DATA_W-1:0] rd_data_reg;
   logic [CW-1:0]               cnt_reg;
   logic                        busy_reg;
   logic                        erase_reg;
   wire                         take = cyc.start & ~busy_reg;
   wire                         last = busy_reg & (cnt_reg == LAST);

   assign cyc.busy    = busy_reg;
   assign cyc.rd_data = rd_data_reg;

   // Counting runs on the system clock only, never on the serial clock.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busy_reg  <= 1'b0;
         cnt_reg   <= '0;
         erase_reg <= 1'b0;
         data_reg  <= '0;
      end else if (take) begin
         busy_reg  <= 1'b1;
         cnt_reg   <= '0;
         erase_reg <= cyc.erase;
         data_reg  <= cyc.data;
      end else if (busy_reg) begin
         busy_reg  <= ~last;
         cnt_reg   <= last ? cnt_reg : cnt_reg + 1'b1;
      end
   end

   // Every word is overwritten outright, so no prior clear is needed.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < sebw_pkg::DEPTH; i++) begin
            mem_reg[i] <= sebw_pkg::ERASED_WORD;
         end
      end else if (last) begin
         for (int i = 0; i < sebw_pkg::DEPTH; i++) begin
            mem_reg[i] <= erase_reg ? sebw_pkg::ERASED_WORD
                                    : data_reg;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_reg <= sebw_pkg::ERASED_WORD;
      end else begin
         rd_data_reg <= mem_reg[cyc.rd_addr];
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_start_busy;
      cyc.start && !busy_reg |=> busy_reg ##1 busy_reg;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("Bulk cycle did not start.");
   property p_erase_ones;
      $fell(busy_reg) && erase_reg |->
         mem_reg[0] == sebw_pkg::ERASED_WORD &&
         mem_reg[sebw_pkg::DEPTH-1] == sebw_pkg::ERASED_WORD;
   endproperty
   a_erase_ones: assert property (p_erase_ones)
      else $error("Erase-all left a bit at zero.");
   property p_write_data;
      $fell(busy_reg) && !erase_reg |-> mem_reg[0] == data_reg;
   endproperty
   a_write_data: assert property (p_write_data)
      else $error("Write-all word not stored.");
   property p_write_any;
      $fell(busy_reg) && !erase_reg |->
         mem_reg[sebw_pkg::DEPTH-1] == mem_reg[0] &&
         mem_reg[sebw_pkg::DEPTH/2] == data_reg;
   endproperty
   a_write_any: assert property (p_write_any)
      else $error("Write-all contents depend on prior data.");
   property p_self_timed;
      $fell(busy_reg) |-> $past(cnt_reg) == LAST;
   endproperty
   a_self_timed: assert property (p_self_timed)
      else $error("Bulk cycle length is wrong.");
   c_erase_done: cover property ($fell(busy_reg) && erase_reg);
   c_write_done: cover property ($fell(busy_reg) && !erase_reg);
endmodule // sebw_bulk_engine

/* sebw_top.sv */
`timescale 1ns/100ps
module sebw_top #(
   parameter int unsigned PROG_CYCLES = sebw_pkg::PROG_CYCLES
) (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        cs_i,
   input  wire logic                        serial_clock_i,
   input  wire logic                        serial_in_i,
   input  wire logic                        word_width_select_i,
   input  wire logic [sebw_pkg::ADDR_W-1:0] rd_addr_i,
   output logic                             dout_o,
   output logic                             dout_oe_b_o,
   output logic                             busy_o,
   output logic                             prog_enabled_o,
   output logic [sebw_pkg::DATA_W-1:0]      rd_data_o
);
   sebw_cyc_if cyc ();

   sebw_bulk_engine #(
      .PROG_CYCLES (PROG_CYCLES)
   ) u_engine (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .cyc     (cyc)
   );

   // Pin synchroniser: a change counts once the second and third stages agree.
   logic [sebw_pkg::PIN_N-1:0] s1_reg;
   logic [sebw_pkg::PIN_N-1:0] s2_reg;
   logic [sebw_pkg::PIN_N-1:0] s3_reg;
   logic [sebw_pkg::PIN_N-1:0] filt_reg;
   wire  [sebw_pkg::PIN_N-1:0] pins;
   wire  [sebw_pkg::PIN_N-1:0] agree;
   wire  [sebw_pkg::PIN_N-1:0] filt_next;

   assign pins  = {word_width_select_i, serial_in_i, serial_clock_i, cs_i};
   assign agree = ~(s2_reg ^ s3_reg);
   assign filt_next = (agree & s3_reg) | (~agree & filt_reg);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg   <= sebw_pkg::PIN_RST;
         s2_reg   <= sebw_pkg::PIN_RST;
         s3_reg   <= sebw_pkg::PIN_RST;
         filt_reg <= sebw_pkg::PIN_RST;
      end else begin
         s1_reg   <= pins;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   wire cs_hi     = filt_next[sebw_pkg::PIN_CS];
   wire cs_fall   = filt_reg[sebw_pkg::PIN_CS] & ~cs_hi;
   wire sclk_rise = filt_next[sebw_pkg::PIN_SCLK] &
                    ~filt_reg[sebw_pkg::PIN_SCLK];
   wire sin_bit   = filt_next[sebw_pkg::PIN_SIN];
   wire word_mode = filt_reg[sebw_pkg::PIN_WSEL];
   wire busy      = cyc.busy;

   // Picks opcode and the two leading address bits out of the header.
   function automatic logic [3:0] head_field(
      input logic [sebw_pkg::SH_W-1:0] sh,
      input logic [4:0]                hdr_len);
      logic [sebw_pkg::SH_W-1:0] shifted;
      shifted = sh >> (hdr_len - sebw_pkg::FIELD_LEN);
      return shifted[3:0];
   endfunction

   sebw_pkg::sebw_state_e      state_reg;
   sebw_pkg::sebw_state_e      state_next;
   logic [sebw_pkg::SH_W-1:0]  sh_reg;
   logic [4:0]                 cnt_reg;
   logic                       enable_reg;
   logic                       enable_next;
   logic                       pend_erase_reg;
   logic                       pend_write_reg;
   logic                       pend_erase_next;
   logic                       pend_write_next;
   logic                       start_reg;
   logic                       status_reg;
   logic                       dout_reg;
   logic                       dout_oe_b_reg;
   logic [sebw_pkg::DATA_W-1:0] data_reg;

   wire [4:0] hdr_len  = word_mode ? sebw_pkg::HDR_LEN_X16
                                   : sebw_pkg::HDR_LEN_X8;
   wire [4:0] data_len = word_mode ? sebw_pkg::DATA_LEN_X16
                                   : sebw_pkg::DATA_LEN_X8;
   wire [4:0] full_len = 5'(hdr_len + data_len);
   wire       shifting = sclk_rise & cs_hi & ~busy;
   wire       shift_en = shifting &
                         (state_reg == sebw_pkg::ST_HDR ||
                          state_reg == sebw_pkg::ST_DATA);
   wire       start_bit = shifting & sin_bit &
                          (state_reg == sebw_pkg::ST_IDLE);
   wire [sebw_pkg::SH_W-1:0] sh_next = {sh_reg[sebw_pkg::SH_W-2:0], sin_bit};
   wire [4:0] cnt_next = cnt_reg + 5'h01;
   wire       hdr_done = shift_en & (state_reg == sebw_pkg::ST_HDR) &
                         (cnt_next == hdr_len);
   wire       data_done = shift_en & (state_reg == sebw_pkg::ST_DATA) &
                          (cnt_next == full_len);
   wire [3:0] fld = head_field(sh_next, hdr_len);
   wire       is_bulk = fld[3:2] == sebw_pkg::OP_BULK;
   wire [1:0] sub = fld[1:0];
   wire [sebw_pkg::DATA_W-1:0] word_in = word_mode ? sh_next[15:0]
                                                   : {2{sh_next[7:0]}};
   wire       launch = cs_fall & enable_reg & ~busy &
                       (pend_erase_reg | pend_write_reg);

   always_comb begin
      state_next      = state_reg;
      enable_next     = enable_reg;
      pend_erase_next = pend_erase_reg;
      pend_write_next = pend_write_reg;
      case (state_reg)
         sebw_pkg::ST_IDLE: begin
            if (start_bit) begin
               state_next = sebw_pkg::ST_HDR;
            end
         end
         sebw_pkg::ST_HDR: begin
            if (hdr_done) begin
               state_next = sebw_pkg::ST_DONE;
               if (is_bulk && sub == sebw_pkg::SUB_ENABLE) begin
                  enable_next = 1'b1;
               end
               if (is_bulk && sub == sebw_pkg::SUB_DISABLE) begin
                  enable_next = 1'b0;
               end
               if (is_bulk && sub == sebw_pkg::SUB_ERASE_ALL) begin
                  pend_erase_next = 1'b1;
               end
               if (is_bulk && sub == sebw_pkg::SUB_WRITE_ALL) begin
                  state_next = sebw_pkg::ST_DATA;
               end
            end
         end
         sebw_pkg::ST_DATA: begin
            if (data_done) begin
               state_next      = sebw_pkg::ST_DONE;
               pend_write_next = 1'b1;
            end
         end
         sebw_pkg::ST_DONE: begin
            state_next = sebw_pkg::ST_DONE;
         end
         default: begin
            state_next = sebw_pkg::ST_IDLE;
         end
      endcase
      if (cs_fall) begin
         state_next      = sebw_pkg::ST_IDLE;
         pend_erase_next = 1'b0;
         pend_write_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg      <= sebw_pkg::ST_IDLE;
         enable_reg     <= 1'b0;
         pend_erase_reg <= 1'b0;
         pend_write_reg <= 1'b0;
      end else begin
         state_reg      <= state_next;
         enable_reg     <= enable_next;
         pend_erase_reg <= pend_erase_next;
         pend_write_reg <= pend_write_next;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sh_reg   <= '0;
         cnt_reg  <= '0;
         data_reg <= '0;
      end else begin
         sh_reg   <= start_bit ? '0 : (shift_en ? sh_next : sh_reg);
         cnt_reg  <= start_bit ? '0 : (shift_en ? cnt_next : cnt_reg);
         data_reg <= data_done ? word_in : data_reg;
      end
   end

   // The launch pulse is one cycle; the engine holds the cycle itself.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         start_reg <= 1'b0;
         cyc.erase <= 1'b0;
      end else begin
         start_reg <= launch;
         cyc.erase <= launch ? pend_erase_reg : cyc.erase;
      end
   end

   assign cyc.start   = start_reg;
   assign cyc.data    = data_reg;
   assign cyc.rd_addr = rd_addr_i;

   // Status shows from launch until a one is clocked in while ready.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_reg    <= 1'b0;
         dout_reg      <= 1'b1;
         dout_oe_b_reg <= 1'b1;
      end else begin
         status_reg    <= start_reg | (status_reg & ~start_bit);
         dout_reg      <= ~busy;
         dout_oe_b_reg <= ~(filt_reg[sebw_pkg::PIN_CS] & status_reg);
      end
   end

   assign dout_o         = dout_reg;
   assign dout_oe_b_o    = dout_oe_b_reg;
   assign busy_o         = busy;
   assign prog_enabled_o = enable_reg;
   assign rd_data_o      = cyc.rd_data;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_status_drive;
      filt_reg[sebw_pkg::PIN_CS] && status_reg |=> !dout_oe_b_o;
   endproperty
   a_status_drive: assert property (p_status_drive)
      else $error("Status not driven while selected.");
   property p_status_level;
      filt_reg[sebw_pkg::PIN_CS] && status_reg && busy
         |=> !dout_o ##1 (dout_o == !$past(busy));
   endproperty
   a_status_level: assert property (p_status_level)
      else $error("Ready/busy level wrong.");
   property p_hdr_len;
      state_reg == sebw_pkg::ST_HDR && shift_en && cnt_next == hdr_len
         && !cs_fall |=> state_reg != sebw_pkg::ST_HDR;
   endproperty
   a_hdr_len: assert property (p_hdr_len)
      else $error("Header length wrong.");
   property p_data_len;
      $rose(pend_write_reg) |-> cnt_reg == full_len;
   endproperty
   a_data_len: assert property (p_data_len)
      else $error("Write-all data length wrong.");
   property p_enabled;
      $rose(busy) |-> $past(enable_reg, 2);
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("Bulk cycle ran while disabled.");
   c_busy_polled: cover property (!dout_oe_b_o && !dout_o);
   c_ready_polled: cover property (!dout_oe_b_o && dout_o);
endmodule // sebw_top

/* sebw_host_model.sv */
`timescale 1ns/100ps
module sebw_host_model (
   input  wire logic clk_i,
   output logic      cs_o,
   output logic      sclk_o,
   output logic      sin_o
);
   initial begin
      cs_o   = 1'b0;
      sclk_o = 1'b0;
      sin_o  = 1'b0;
   end

   // Sends n bits MSB first after a deselect gap; the serial clock rests low.
   task automatic send(input logic [26:0] bits, input int n);
      repeat (8) @(posedge clk_i);
      cs_o <= 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         sin_o <= bits[i];
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      sin_o <= ~sin_o;
      repeat (4) @(posedge clk_i);
      cs_o <= 1'b0;
   endtask

   // Selects or deselects the device without any serial clock.
   task automatic select(input logic v);
      @(posedge clk_i);
      cs_o <= v;
   endtask
endmodule // sebw_host_model

/* serial_eeprom_bulk_erase_write_bench.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
   err_total++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module serial_eeprom_bulk_erase_write_bench;
   localparam int unsigned PROG_CYC = 20;
   logic        clk_i               = 1'b0;
   logic        rst_b_i             = 1'b0;
   logic        word_width_select_i = 1'b1;
   logic [7:0]  rd_addr_i           = 8'h00;
   logic        cs_w;
   logic        sclk_w;
   logic        sin_w;
   logic        dout_o;
   logic        dout_oe_b_o;
   logic        busy_o;
   logic        prog_enabled_o;
   logic [15:0] rd_data_o;
   int          err_total           = 0;
   int          num_checks          = 0;

   always #50 clk_i = ~clk_i;

   sebw_host_model sebw_host_model_i (
      .clk_i  (clk_i),
      .cs_o   (cs_w),
      .sclk_o (sclk_w),
      .sin_o  (sin_w)
   );

   sebw_top #(.PROG_CYCLES(PROG_CYC)) sebw_top_i (
      .clk_i               (clk_i),
      .rst_b_i             (rst_b_i),
      .cs_i                (cs_w),
      .serial_clock_i      (sclk_w),
      .serial_in_i         (sin_w),
      .word_width_select_i (word_width_select_i),
      .rd_addr_i           (rd_addr_i),
      .dout_o              (dout_o),
      .dout_oe_b_o         (dout_oe_b_o),
      .busy_o              (busy_o),
      .prog_enabled_o      (prog_enabled_o),
      .rd_data_o           (rd_data_o)
   );

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Builds a bulk instruction for the current word width and sends it.
   task automatic cmd(input logic [1:0] sub, input logic [15:0] d);
      logic [26:0] bits;
      int          n;
      bits = {16'h0000, 1'h1, sebw_pkg::OP_BULK, sub, 6'h00};
      n = 11;
      if (word_width_select_i === 1'b0) begin
         bits = {15'h0000, 1'h1, sebw_pkg::OP_BULK, sub, 7'h00};
         n = 12;
      end
      if (sub == sebw_pkg::SUB_WRITE_ALL) begin
         bits = (word_width_select_i === 1'b0) ? {bits[18:0], d[7:0]} :
                                                 {bits[10:0], d};
         n = (word_width_select_i === 1'b0) ? 20 : 27;
      end
      sebw_host_model_i.send(bits, n);
   endtask

   task automatic check_array(input logic [15:0] exp);
      logic [7:0] a [3] = '{8'h00, 8'h7F, 8'hFF};
      foreach (a[k]) begin
         @(posedge clk_i);
         rd_addr_i <= a[k];
         repeat (2) @(negedge clk_i);
         `CHK("rd_data_o", exp, rd_data_o)
      end
   endtask

   task automatic no_cycle();
      logic seen;
      seen = 1'b0;
      repeat (30) begin
         @(negedge clk_i);
         if (busy_o !== 1'b0) seen = 1'b1;
      end
      `CHK("refused busy_o", 1'b0, seen)
   endtask

   // Waits for the cycle, polls status during it and checks the result.
   task automatic run_bulk(input logic [15:0] exp);
      int   cnt;
      logic saw_low;
      @(negedge clk_i);
      `CHK("busy_o before deselect", 1'b0, busy_o)
      for (int i = 0; i < 10 && busy_o !== 1'b1; i++) @(negedge clk_i);
      if (busy_o !== 1'b1) begin
         err_total++;
         $display("ERROR busy_o expected 1 seen %b", busy_o);
         end_of_test();
      end
      cnt = 1;
      saw_low = 1'b0;
      sebw_host_model_i.select(1'b1);
      for (int i = 0; i < 40 && busy_o === 1'b1; i++) begin
         @(negedge clk_i);
         if (busy_o === 1'b1) cnt++;
         if (dout_oe_b_o === 1'b0 && dout_o === 1'b0) saw_low = 1'b1;
      end
      `CHK("busy cycles", PROG_CYC, cnt)
      `CHK("status busy seen", 1'b1, saw_low)
      @(negedge clk_i);
      `CHK("dout_o ready", 1'b1, dout_o)
      `CHK("dout_oe_b_o ready", 1'b0, dout_oe_b_o)
      sebw_host_model_i.select(1'b0);
      check_array(exp);
   endtask

   task automatic t_reset();
      @(negedge clk_i);
      `CHK("dout_oe_b_o reset", 1'b1, dout_oe_b_o)
      `CHK("busy_o reset", 1'b0, busy_o)
      `CHK("prog_enabled_o reset", 1'b0, prog_enabled_o)
      check_array(sebw_pkg::ERASED_WORD);
   endtask

   task automatic t_locked();
      cmd(sebw_pkg::SUB_WRITE_ALL, 16'h1234);
      no_cycle();
      check_array(sebw_pkg::ERASED_WORD);
   endtask

   task automatic t_enable();
      cmd(sebw_pkg::SUB_ENABLE, 16'h0000);
      repeat (8) @(negedge clk_i);
      `CHK("prog_enabled_o", 1'b1, prog_enabled_o)
   endtask

   task automatic t_write16();
      cmd(sebw_pkg::SUB_WRITE_ALL, 16'hA5C3);
      run_bulk(16'hA5C3);
   endtask

   task automatic t_write8();
      @(posedge clk_i);
      word_width_select_i <= 1'b0;
      @(posedge clk_i);
      cmd(sebw_pkg::SUB_WRITE_ALL, 16'h003C);
      run_bulk(16'h3C3C);
   endtask

   task automatic t_disable();
      cmd(sebw_pkg::SUB_DISABLE, 16'h0000);
      repeat (8) @(negedge clk_i);
      `CHK("prog_enabled_o off", 1'b0, prog_enabled_o)
      cmd(sebw_pkg::SUB_ERASE_ALL, 16'h0000);
      no_cycle();
      check_array(16'h3C3C);
   endtask

   task automatic t_erase();
      @(posedge clk_i);
      word_width_select_i <= 1'b1;
      @(posedge clk_i);
      t_enable();
      cmd(sebw_pkg::SUB_ERASE_ALL, 16'h0000);
      run_bulk(sebw_pkg::ERASED_WORD);
   endtask

   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_reset();
      t_locked();
      t_enable();
      t_write16();
      t_write8();
      t_disable();
      t_erase();
      end_of_test();
   end
endmodule // serial_eeprom_bulk_erase_write_bench
